/* rtl/bd_engine_map.svh */
// Functional notes
// - Completion writes token PID into status bits 5:2
// - Engine may overwrite owned status byte freely
// - Count overflow past eight bits goes to status 1:0
// - IN sends descriptor count, returns bytes sent
// - OUT count is limit; return bytes received
// - Oversized OUT packet gets NAK, count unchanged
// - Byte count is ten bits, 0 to 1023
// - Status write-back leaves bit 6 untouched
// - Two-bit field selects one of four ping-pong modes
// - Per-endpoint even/odd pointer, held even while disabled
// - Ping-pong pointer toggles after each completed transaction
// - Transfer status records even or odd descriptor used
// - Pointer-reset control forces all pointers to even
// - Descriptor index mapping for modes 0 and 1
// - Descriptor index mapping for modes 2 and 3
// - Table holds 32 four-byte descriptors
// - Descriptor bytes have no assumed reset value
// - Processor rewrites toggle-check and stall before rearming
// - Expected toggle ignored unless toggle check enabled
// - All USB sources funnel to processor flag bit 2
// - Any enabled error flag sets top error flag
// - Engine clears ownership flag when transaction completes
`ifndef BD_ENGINE_MAP_SVH
`define BD_ENGINE_MAP_SVH
`define BD_COUNT 32
`define EP_COUNT 8
`define BD_STAT_OFS 2'h0
`define BD_CNT_OFS 2'h1
`define BD_ADRL_OFS 2'h2
`define BD_ADRH_OFS 2'h3
`define STAT_OWN 7
`define STAT_TOGGLE 6
`define STAT_TSEN 3
`define STAT_STALL 2
`define PID_OUT 4'h1
`define PID_IN 4'h9
`define PID_SETUP 4'hd
`define TRANSFER_STATUS_REGISTER_EP_LO 3
`define TRANSFER_STATUS_REGISTER_DIR 2
`define TRANSFER_STATUS_REGISTER_LAST_EVEN_ODD_INDICATOR 1
`define IRQ_URST 0
`define IRQ_ERR 1
`define IRQ_ACTV 2
`define IRQ_TRN 3
`define IRQ_IDLE 4
`define IRQ_STALL 5
`define IRQ_SOF 6
`define PIR_USB_BIT 2
`endif

/* rtl/bd_engine_pkg.sv */
package bd_engine_pkg;
	typedef enum logic [1:0] {MODE_NONE, MODE_EP0_OUT, MODE_ALL, MODE_ALL_BUT_EP0} buf_mode_t;
	typedef enum logic [1:0] {HS_NONE, HS_ACK, HS_NAK, HS_STALL} hs_t;
	typedef enum logic [1:0] {ST_IDLE, ST_CHECK, ST_IN_WAIT} fsm_t;
endpackage

/* rtl/bd_index_map.sv */
`timescale 1ns/1ns
`default_nettype none
module bd_index_map
(
	// Lookup request
	input wire bd_engine_pkg::buf_mode_t i_mode,
	input wire logic [2:0] i_ep,
	input wire logic i_is_in,
	input wire logic i_odd,
	// Result
	output logic [4:0] o_index,
	output logic o_pingpong
);
	import bd_engine_pkg::*;
	logic [5:0] n2;
	logic [5:0] n4;
	logic [5:0] t;
	always_comb
	begin
		n2 = {2'h0, i_ep, 1'b0};
		n4 = {1'b0, i_ep, 2'h0};
		t = 6'h00;
		o_pingpong = 1'b0;
		unique case (i_mode)
			MODE_NONE:
			begin
				t = n2 + {5'h00, i_is_in};
			end
			MODE_EP0_OUT:
			begin
				if (i_ep == 3'h0)
				begin
					o_pingpong = !i_is_in;
					t = i_is_in ? 6'h02 : {5'h00, i_odd};
				end
				else
				begin
					t = n2 + 6'h01 + {5'h00, i_is_in};
				end
			end
			MODE_ALL:
			begin
				o_pingpong = 1'b1;
				t = n4 + {4'h0, i_is_in, i_odd};
			end
			MODE_ALL_BUT_EP0:
			begin
				if (i_ep == 3'h0)
				begin
					t = {5'h00, i_is_in};
				end
				else
				begin
					o_pingpong = 1'b1;
					t = n4 - 6'h02 + {4'h0, i_is_in, i_odd};
				end
			end
		endcase
		o_index = t[4:0];
	end
endmodule
`default_nettype wire

/* rtl/irq_flag_bank.sv */
`timescale 1ns/1ns
`default_nettype none
module irq_flag_bank #(
	parameter int W = 8
)
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Events, software clears, enables
	input wire logic [W-1:0] i_set,
	input wire logic [W-1:0] i_clr,
	input wire logic [W-1:0] i_en,
	// Flags
	output logic [W-1:0] o_flags,
	output logic o_any
);
	typedef struct packed {
		logic [W-1:0] flags;
	} bank_t;
	bank_t s_reg;
	bank_t s_next;
	always_comb
	begin
		// Set wins over a clear in the same cycle so no event is lost
		s_next.flags = (s_reg.flags & ~i_clr) | i_set;
	end
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end
	assign o_flags = s_reg.flags;
	assign o_any = |(s_reg.flags & i_en);
endmodule
`default_nettype wire

/* rtl/bd_engine.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bd_engine_map.svh"
module bd_engine
(
	// Clock and reset
	input wire logic i_clk,
	input wire logic i_reset,
	// Configuration
	input wire logic i_module_en,
	input wire bd_engine_pkg::buf_mode_t i_buffering_mode_field,
	input wire logic i_pointer_reset_control,
	// Processor access to the descriptor table
	input wire logic i_cpu_sel,
	input wire logic i_cpu_we,
	input wire logic [6:0] i_cpu_addr,
	input wire logic [7:0] i_cpu_wdata,
	output logic [7:0] o_cpu_rdata,
	// Token from the serial engine
	input wire logic i_tok_valid,
	input wire logic [3:0] i_tok_pid,
	input wire logic [2:0] i_tok_ep,
	input wire logic [9:0] i_out_len,
	input wire logic i_out_toggle,
	input wire logic i_out_err,
	// Handshake answer
	output bd_engine_pkg::hs_t o_handshake,
	output logic o_handshake_valid,
	// IN data request
	output logic o_in_start,
	output logic [9:0] o_in_len,
	output logic [15:0] o_in_addr,
	input wire logic i_in_done,
	input wire logic [9:0] i_in_sent,
	// Status
	output logic [7:0] o_transfer_status_register,
	// Interrupts
	input wire logic [6:0] i_status_events,
	input wire logic [6:0] i_status_clr,
	input wire logic [6:0] i_status_irq_enables,
	input wire logic [7:0] i_err_events,
	input wire logic [7:0] i_err_clr,
	input wire logic [7:0] i_error_irq_enables,
	output logic [7:0] o_status_irq_flags,
	output logic [7:0] o_error_irq_flags,
	output logic [7:0] o_processor_irq_flags_two
);
	import bd_engine_pkg::*;
	typedef struct packed {
		fsm_t st;
		logic [`BD_COUNT*4-1:0][7:0] bd;
		logic [`EP_COUNT*2-1:0] ptr;
		logic [3:0] pid;
		logic [2:0] ep;
		logic is_in;
		logic odd;
		logic pp;
		logic [4:0] idx;
		logic [4:0] last_idx;
		logic [9:0] olen;
		logic otog;
		logic oerr;
		hs_t hs;
		logic hs_valid;
		logic in_start;
		logic [9:0] in_len;
		logic [15:0] in_addr;
		logic [7:0] transfer_status_register;
		logic trn_set;
		logic stall_set;
		logic [7:0] rdata;
		logic summary;
	} core_t;
	core_t s_reg;
	core_t s_next;
	logic tok_is_in;
	logic [3:0] tok_slot;
	logic [4:0] map_idx;
	logic map_pp;
	logic [6:0] stat_a;
	logic [6:0] cnt_a;
	logic [7:0] cur_stat;
	logic [9:0] max_cnt;
	logic [3:0] ptr_i;
	logic wb_fire;
	logic [9:0] wb_count;
	logic [6:0] st_flags;
	logic err_any;
	logic [7:0] status_full;
	logic [7:0] lst_stat;
	logic [7:0] lst_cnt;

	assign tok_is_in = (i_tok_pid == `PID_IN);
	assign tok_slot = {i_tok_ep, tok_is_in};

	bd_index_map u_map (
		.i_mode(i_buffering_mode_field),
		.i_ep(i_tok_ep),
		.i_is_in(tok_is_in),
		.i_odd(s_reg.ptr[tok_slot]),
		.o_index(map_idx),
		.o_pingpong(map_pp)
	);

	assign stat_a = {s_reg.idx, `BD_STAT_OFS};
	assign cnt_a = {s_reg.idx, `BD_CNT_OFS};
	assign cur_stat = s_reg.bd[stat_a];
	assign max_cnt = {cur_stat[1:0], s_reg.bd[cnt_a]};
	assign ptr_i = {s_reg.ep, s_reg.is_in};
	assign lst_stat = s_reg.bd[{s_reg.last_idx, `BD_STAT_OFS}];
	assign lst_cnt = s_reg.bd[{s_reg.last_idx, `BD_CNT_OFS}];

	// Hand the descriptor back with the returned count
	function automatic core_t finish(input core_t c, input logic [9:0] n);
		core_t r;
		r = c;
		// Bit 6 is carried over, never rewritten
		r.bd[stat_a] = {1'b0, cur_stat[`STAT_TOGGLE], c.pid, n[9:8]};
		r.bd[cnt_a] = n[7:0];
		if (c.pp)
			r.ptr[ptr_i] = !c.ptr[ptr_i];
		r.last_idx = c.idx;
		r.transfer_status_register = 8'h00;
		r.transfer_status_register[`TRANSFER_STATUS_REGISTER_EP_LO +: 3] = c.ep;
		r.transfer_status_register[`TRANSFER_STATUS_REGISTER_DIR] = c.is_in;
		r.transfer_status_register[`TRANSFER_STATUS_REGISTER_LAST_EVEN_ODD_INDICATOR] = c.odd;
		r.trn_set = 1'b1;
		r.st = ST_IDLE;
		return r;
	endfunction

	always_comb
	begin
		s_next = s_reg;
		wb_fire = 1'b0;
		wb_count = 10'h000;
		s_next.hs_valid = 1'b0;
		s_next.hs = HS_NONE;
		s_next.in_start = 1'b0;
		s_next.trn_set = 1'b0;
		s_next.stall_set = 1'b0;
		// Buffer addresses are used as written; nothing validates them
		if (i_cpu_sel)
		begin
			s_next.rdata = s_reg.bd[i_cpu_addr];
			if (i_cpu_we)
				s_next.bd[i_cpu_addr] = i_cpu_wdata;
		end
		// No lockout while owned; engine writes below win over the processor
		unique case (s_reg.st)
			ST_IDLE:
			begin
				if (i_tok_valid)
				begin
					s_next.pid = i_tok_pid;
					s_next.ep = i_tok_ep;
					s_next.is_in = tok_is_in;
					s_next.idx = map_idx;
					s_next.pp = map_pp;
					s_next.odd = map_pp & s_reg.ptr[tok_slot];
					s_next.olen = i_out_len;
					s_next.otog = i_out_toggle;
					s_next.oerr = i_out_err;
					s_next.st = ST_CHECK;
				end
			end
			ST_CHECK:
			begin
				s_next.st = ST_IDLE;
				s_next.hs_valid = !s_reg.is_in;
				if (!cur_stat[`STAT_OWN])
				begin
					s_next.hs = HS_NAK;
					s_next.hs_valid = 1'b1;
				end
				else if (cur_stat[`STAT_STALL] && s_reg.pid != `PID_SETUP)
				begin
					// Setup is exempt from the stall and completes normally
					s_next.hs = HS_STALL;
					s_next.hs_valid = 1'b1;
					s_next.stall_set = 1'b1;
				end
				else if (s_reg.is_in)
				begin
					s_next.in_start = 1'b1;
					s_next.in_len = max_cnt;
					s_next.in_addr = {s_reg.bd[{s_reg.idx, `BD_ADRH_OFS}],
						s_reg.bd[{s_reg.idx, `BD_ADRL_OFS}]};
					s_next.st = ST_IN_WAIT;
				end
				else if (s_reg.oerr || s_reg.olen > max_cnt)
				begin
					s_next.hs = HS_NAK;
				end
				else if (cur_stat[`STAT_TSEN] && s_reg.otog != cur_stat[`STAT_TOGGLE]
					&& s_reg.pid != `PID_SETUP)
				begin
					// Wrong toggle is acknowledged but dropped
					s_next.hs = HS_ACK;
				end
				else
				begin
					s_next.hs = HS_ACK;
					wb_fire = 1'b1;
					wb_count = s_reg.olen;
					s_next = finish(s_next, s_reg.olen);
				end
			end
			ST_IN_WAIT:
			begin
				if (i_in_done)
				begin
					wb_fire = 1'b1;
					wb_count = i_in_sent;
					s_next = finish(s_next, i_in_sent);
				end
			end
		endcase
		// Settings in bits 5:2 are stale after write-back until rearmed
		if (!i_module_en)
		begin
			s_next.ptr = '0;
			s_next.st = ST_IDLE;
		end
		if (i_pointer_reset_control)
			s_next.ptr = '0;
		s_next.summary = |(status_full[6:0] & i_status_irq_enables);
	end

	// Descriptor bytes reset only for determinism; no logic relies on it
	always_ff @(posedge i_clk or posedge i_reset)
	begin
		if (i_reset)
			s_reg <= '0;
		else
			s_reg <= s_next;
	end

	irq_flag_bank #(.W(7)) u_status (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_set({i_status_events[`IRQ_SOF], s_reg.stall_set, i_status_events[`IRQ_IDLE],
			s_reg.trn_set, i_status_events[`IRQ_ACTV], 1'b0, i_status_events[`IRQ_URST]}),
		.i_clr(i_status_clr & 7'h7d),
		.i_en(i_status_irq_enables),
		.o_flags(st_flags),
		.o_any()
	);

	irq_flag_bank #(.W(8)) u_error (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_set(i_err_events),
		.i_clr(i_err_clr),
		.i_en(i_error_irq_enables),
		.o_flags(o_error_irq_flags),
		.o_any(err_any)
	);

	// Error summary is a status, not a latched flag
	assign status_full = {1'b0, st_flags[6:2], err_any, st_flags[0]};
	assign o_status_irq_flags = status_full;
	assign o_processor_irq_flags_two = {7'h00, s_reg.summary} << `PIR_USB_BIT;
	assign o_cpu_rdata = s_reg.rdata;
	assign o_handshake = s_reg.hs;
	assign o_handshake_valid = s_reg.hs_valid;
	assign o_in_start = s_reg.in_start;
	assign o_in_len = s_reg.in_len;
	assign o_in_addr = s_reg.in_addr;
	assign o_transfer_status_register = s_reg.transfer_status_register;

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_pid_written: assert property (wb_fire |=> lst_stat[5:2] == $past(s_reg.pid))
		else $error("pid not written back");
	a_bit6_kept: assert property (wb_fire |=> lst_stat[6] == $past(cur_stat[6]))
		else $error("bit 6 changed on write-back");
	a_owner_released: assert property (wb_fire && !i_cpu_sel |=> !lst_stat[7])
		else $error("ownership not released");
	a_count_split: assert property (wb_fire |=> {lst_stat[1:0], lst_cnt} == $past(wb_count))
		else $error("count not split into status and count byte");
	a_overflow_nak: assert property ((s_reg.st == ST_CHECK && !s_reg.is_in && cur_stat[7]
		&& !cur_stat[2] && s_reg.olen > max_cnt)
		|-> !wb_fire ##1 o_handshake_valid && o_handshake == HS_NAK)
		else $error("oversized packet not refused");
	a_in_length: assert property (o_in_start |-> o_in_len == $past(max_cnt))
		else $error("in length differs from descriptor count");
	a_ptr_flip: assert property ((wb_fire && s_reg.pp && i_module_en && !i_pointer_reset_control)
		|=> s_reg.ptr[$past(ptr_i)] != $past(s_reg.ptr[ptr_i]))
		else $error("pointer did not toggle");
	a_ptr_clear: assert property (i_pointer_reset_control |=> s_reg.ptr == '0)
		else $error("pointer reset ignored");
	a_enable_even: assert property (!i_module_en |=> s_reg.ptr == '0)
		else $error("pointers not even while disabled");
	a_error_funnel: assert property (|(o_error_irq_flags & i_error_irq_enables)
		|-> o_status_irq_flags[`IRQ_ERR])
		else $error("error flag not raised");
	a_summary_bit: assert property ($rose(s_next.summary) |=> o_processor_irq_flags_two[2])
		else $error("summary request missing");
	a_transfer_status_register_odd: assert property (wb_fire |=>
		o_transfer_status_register[`TRANSFER_STATUS_REGISTER_LAST_EVEN_ODD_INDICATOR] == $past(s_reg.pp && s_reg.idx[0]))
		else $error("even/odd indicator wrong");
	a_transfer_status_register_source: assert property (wb_fire |=>
		o_transfer_status_register[`TRANSFER_STATUS_REGISTER_EP_LO +: 3] == $past(s_reg.ep)
		&& o_transfer_status_register[`TRANSFER_STATUS_REGISTER_DIR] == $past(s_reg.is_in))
		else $error("transfer status source wrong");
	// Outcomes of the check and IN wait cycles, then the summary request; only a clean packet may touch the descriptor
	a_unowned_nak: assert property ((s_reg.st == ST_CHECK && !cur_stat[`STAT_OWN])
		|-> !wb_fire ##1 o_handshake_valid && o_handshake == HS_NAK)
		else $error("descriptor used without ownership");
	a_stall_hold: assert property ((s_reg.st == ST_CHECK && cur_stat[`STAT_OWN]
		&& cur_stat[`STAT_STALL] && s_reg.pid != `PID_SETUP)
		|-> !wb_fire ##1 o_handshake_valid && o_handshake == HS_STALL)
		else $error("stalled descriptor not answered with stall");
	a_toggle_ignored: assert property ((s_reg.st == ST_CHECK && !s_reg.is_in
		&& cur_stat[`STAT_OWN] && !cur_stat[`STAT_STALL] && !cur_stat[`STAT_TSEN]
		&& !s_reg.oerr && s_reg.olen <= max_cnt) |-> wb_fire)
		else $error("toggle used although checking is off");
	a_toggle_check: assert property ((s_reg.st == ST_CHECK && !s_reg.is_in
		&& cur_stat[`STAT_OWN] && !cur_stat[`STAT_STALL] && cur_stat[`STAT_TSEN]
		&& !s_reg.oerr && s_reg.olen <= max_cnt && s_reg.pid != `PID_SETUP
		&& s_reg.otog != cur_stat[`STAT_TOGGLE])
		|-> !wb_fire ##1 o_handshake_valid && o_handshake == HS_ACK)
		else $error("wrong toggle not dropped with ack");
	a_count_kept: assert property ((s_reg.st == ST_CHECK && !s_reg.is_in
		&& s_reg.olen > max_cnt && !i_cpu_sel) |=> max_cnt == $past(max_cnt))
		else $error("count changed on refused packet");
	a_in_address: assert property (o_in_start |-> o_in_addr ==
		$past({s_reg.bd[{s_reg.idx, `BD_ADRH_OFS}], s_reg.bd[{s_reg.idx, `BD_ADRL_OFS}]}))
		else $error("buffer address not used as written");
	a_in_writeback: assert property ((s_reg.st == ST_IN_WAIT && i_in_done)
		|-> wb_fire && wb_count == i_in_sent)
		else $error("in count not written back");
	a_summary_track: assert property (o_processor_irq_flags_two[`PIR_USB_BIT]
		== $past(|(o_status_irq_flags[6:0] & i_status_irq_enables)))
		else $error("summary request does not follow the flags");

	c_out_done: cover property (wb_fire && !s_reg.is_in);
	c_setup_done: cover property (wb_fire && s_reg.pid == `PID_SETUP);
	c_odd_done: cover property (wb_fire && s_reg.odd);
	c_in_done: cover property (wb_fire && s_reg.is_in);
	c_stall: cover property (o_handshake_valid && o_handshake == HS_STALL);
endmodule
`default_nettype wire

/* bench/usb_host_model.sv */
`timescale 1ns/1ns
`default_nettype none
module usb_host_model
(
	// Clock
	input wire logic i_clk,
	// IN data request from the engine
	input wire logic i_in_start,
	input wire logic [9:0] i_in_len,
	// Completion back to the engine
	output logic o_in_done,
	output logic [9:0] o_in_sent
);
	initial
	begin
		o_in_done = 1'b0;
		o_in_sent = 10'h000;
		forever
		begin
			@(negedge i_clk);
			if (i_in_start === 1'b1)
			begin
				repeat (3) @(negedge i_clk);
				// One short of the count, so the write-back of the actual figure shows
				o_in_sent = i_in_len - 10'h001;
				o_in_done = 1'b1;
				@(negedge i_clk);
				o_in_done = 1'b0;
				// Stale count must not look valid once done has dropped
				o_in_sent = ~o_in_sent;
			end
		end
	end
endmodule
`default_nettype wire

/* bench/usb_buffer_descriptor_engine_tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "bd_engine_map.svh"
module usb_buffer_descriptor_engine_tb;
	import bd_engine_pkg::*;
	logic i_clk, i_reset, module_en, ptr_rst, cpu_sel, cpu_we, tok_valid, out_tgl, out_err;
	buf_mode_t mode;
	logic [6:0] cpu_addr, st_ev, st_clr, st_en;
	logic [7:0] wdata, rdata, transfer_status_register, st_flags, err_flags, pir, err_ev, err_clr, err_en;
	logic [3:0] tok_pid;
	logic [2:0] tok_ep;
	logic [9:0] out_len, in_len, in_sent;
	logic [15:0] in_addr;
	logic hs_valid, in_start, in_done;
	hs_t hs_out, hs;
	int n_errors = 0;
	int comparisons = 0;
	bd_engine dut_u (.i_clk(i_clk), .i_reset(i_reset), .i_module_en(module_en),
		.i_buffering_mode_field(mode), .i_pointer_reset_control(ptr_rst),
		.i_cpu_sel(cpu_sel), .i_cpu_we(cpu_we), .i_cpu_addr(cpu_addr), .i_cpu_wdata(wdata),
		.o_cpu_rdata(rdata), .i_tok_valid(tok_valid), .i_tok_pid(tok_pid), .i_tok_ep(tok_ep),
		.i_out_len(out_len), .i_out_toggle(out_tgl), .i_out_err(out_err),
		.o_handshake(hs_out), .o_handshake_valid(hs_valid), .o_in_start(in_start),
		.o_in_len(in_len), .o_in_addr(in_addr), .i_in_done(in_done), .i_in_sent(in_sent),
		.o_transfer_status_register(transfer_status_register), .i_status_events(st_ev), .i_status_clr(st_clr),
		.i_status_irq_enables(st_en), .i_err_events(err_ev), .i_err_clr(err_clr),
		.i_error_irq_enables(err_en), .o_status_irq_flags(st_flags),
		.o_error_irq_flags(err_flags), .o_processor_irq_flags_two(pir));
	usb_host_model host_u (.i_clk(i_clk), .i_in_start(in_start), .i_in_len(in_len),
		.o_in_done(in_done), .o_in_sent(in_sent));
	initial
	begin
		i_clk = 1'b0;
		forever #20 i_clk = ~i_clk;
	end
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_errors++;
			$display("mismatch at %0t got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
		chk16({8'h00, got}, {8'h00, exp});
	endtask
	task automatic cpu_wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge i_clk);
		cpu_sel = 1'b1;
		cpu_we = 1'b1;
		cpu_addr = a;
		wdata = d;
		@(negedge i_clk);
		cpu_sel = 1'b0;
		cpu_we = 1'b0;
	endtask
	task automatic rd_chk(input logic [6:0] a, input logic [7:0] exp);
		@(negedge i_clk);
		cpu_sel = 1'b1;
		cpu_addr = a;
		@(negedge i_clk);
		cpu_sel = 1'b0;
		chk8(rdata, exp);
	endtask
	// Status byte goes last so the engine never sees a half-built descriptor
	task automatic arm(input logic [4:0] d, input logic [7:0] st, input logic [7:0] cnt,
		input logic [15:0] adr);
		cpu_wr({d, 2'h1}, cnt);
		cpu_wr({d, 2'h2}, adr[7:0]);
		cpu_wr({d, 2'h3}, adr[15:8]);
		cpu_wr({d, 2'h0}, st);
	endtask
	task automatic ppr();
		@(negedge i_clk);
		ptr_rst = 1'b1;
		@(negedge i_clk);
		ptr_rst = 1'b0;
	endtask
	task automatic tok(input logic [3:0] pid, input logic [2:0] ep, input logic [9:0] len,
		input logic tgl);
		int i;
		@(negedge i_clk);
		tok_valid = 1'b1;
		tok_pid = pid;
		tok_ep = ep;
		out_len = len;
		out_tgl = tgl;
		@(negedge i_clk);
		tok_valid = 1'b0;
		hs = HS_NONE;
		for (i = 0; i < 30; i++)
		begin
			@(negedge i_clk);
			if (hs_valid === 1'b1)
			begin
				hs = hs_out;
				break;
			end
			if (in_start === 1'b1)
			begin
				repeat (8) @(negedge i_clk);
				hs = HS_ACK;
				break;
			end
		end
		chk8(8'(i < 30), 8'h01);
	endtask
	task automatic t_out();
		mode = MODE_NONE;
		arm(5'd2, 8'hc1, 8'hff, 16'h0000);
		tok(`PID_OUT, 3'd1, 10'h200, 1'b0);
		chk8(8'(hs), 8'(HS_NAK));
		rd_chk(7'h08, 8'hc1);
		out_err = 1'b1;
		tok(`PID_OUT, 3'd1, 10'h001, 1'b0);
		out_err = 1'b0;
		chk8(8'(hs), 8'(HS_NAK));
		tok(`PID_OUT, 3'd1, 10'h1ff, 1'b0);
		chk8(8'(hs), 8'(HS_ACK));
		rd_chk(7'h08, 8'h45);
		rd_chk(7'h09, 8'hff);
		chk8(transfer_status_register, 8'h08);
		$display("out test done");
	endtask
	task automatic t_in();
		arm(5'd5, 8'h83, 8'h03, 16'h1234);
		tok(`PID_IN, 3'd2, 10'h000, 1'b0);
		chk16(16'(in_len), 16'h0303);
		chk16(in_addr, 16'h1234);
		rd_chk(7'h14, 8'h27);
		rd_chk(7'h15, 8'h02);
		chk8(transfer_status_register, 8'h14);
		$display("in test done");
	endtask
	task automatic t_tog();
		arm(5'd2, 8'h88, 8'h10, 16'h0000);
		tok(`PID_OUT, 3'd1, 10'h003, 1'b1);
		chk8(8'(hs), 8'(HS_ACK));
		rd_chk(7'h08, 8'h88);
		tok(`PID_OUT, 3'd1, 10'h003, 1'b0);
		rd_chk(7'h08, 8'h04);
		tok(`PID_OUT, 3'd1, 10'h003, 1'b0);
		chk8(8'(hs), 8'(HS_NAK));
		arm(5'd2, 8'h84, 8'h10, 16'h0000);
		tok(`PID_OUT, 3'd1, 10'h003, 1'b0);
		chk8(8'(hs), 8'(HS_STALL));
		tok(`PID_SETUP, 3'd1, 10'h008, 1'b0);
		chk8(8'(hs), 8'(HS_ACK));
		chk8(st_flags & 8'h20, 8'h20);
		rd_chk(7'h08, 8'h34);
		$display("toggle test done");
	endtask
	task automatic t_pp();
		mode = MODE_ALL;
		ppr();
		arm(5'd0, 8'h80, 8'h08, 16'h0000);
		arm(5'd1, 8'h80, 8'h08, 16'h0000);
		tok(`PID_OUT, 3'd0, 10'h004, 1'b0);
		chk8(transfer_status_register, 8'h00);
		rd_chk(7'h00, 8'h04);
		ppr();
		arm(5'd0, 8'h80, 8'h08, 16'h0000);
		tok(`PID_OUT, 3'd0, 10'h004, 1'b0);
		rd_chk(7'h04, 8'h80);
		tok(`PID_OUT, 3'd0, 10'h004, 1'b0);
		chk8(transfer_status_register, 8'h02);
		rd_chk(7'h04, 8'h04);
		arm(5'd0, 8'h80, 8'h08, 16'h0000);
		tok(`PID_OUT, 3'd0, 10'h004, 1'b0);
		@(negedge i_clk);
		module_en = 1'b0;
		@(negedge i_clk);
		module_en = 1'b1;
		arm(5'd0, 8'h80, 8'h08, 16'h0000);
		tok(`PID_OUT, 3'd0, 10'h004, 1'b0);
		chk8(8'(hs), 8'(HS_ACK));
		chk8(transfer_status_register, 8'h00);
		$display("ping-pong test done");
	endtask
	task automatic t_map();
		logic [10:0] tbl [7];
		logic [10:0] e;
		tbl = '{{2'd0, 3'd3, 1'b0, 5'd6}, {2'd1, 3'd0, 1'b1, 5'd2}, {2'd1, 3'd2, 1'b0, 5'd5},
			{2'd2, 3'd7, 1'b1, 5'd30}, {2'd3, 3'd0, 1'b1, 5'd1}, {2'd3, 3'd2, 1'b0, 5'd6},
			{2'd3, 3'd7, 1'b1, 5'd28}};
		foreach (tbl[k])
		begin
			e = tbl[k];
			mode = buf_mode_t'(e[10:9]);
			ppr();
			arm(e[4:0], 8'h80, 8'h02, 16'h0000);
			tok(e[5] ? `PID_IN : `PID_OUT, e[8:6], 10'h002, 1'b0);
			rd_chk({e[4:0], 2'h0}, e[5] ? 8'h24 : 8'h04);
			chk8(transfer_status_register, {2'b00, e[8:6], e[5], 2'b00});
		end
		$display("mapping test done");
	endtask
	task automatic t_irq();
		st_en = 7'h02;
		err_en = 8'h01;
		@(negedge i_clk);
		st_clr = 7'h7f;
		err_ev = 8'h02;
		@(negedge i_clk);
		st_clr = 7'h00;
		err_ev = 8'h00;
		repeat (3) @(negedge i_clk);
		chk8(err_flags, 8'h02);
		chk8(st_flags, 8'h00);
		chk8(pir, 8'h00);
		err_ev = 8'h01;
		@(negedge i_clk);
		err_ev = 8'h00;
		repeat (3) @(negedge i_clk);
		chk8(st_flags, 8'h02);
		chk8(pir, 8'h04);
		st_en = 7'h42;
		err_clr = 8'hff;
		st_ev = 7'h40;
		@(negedge i_clk);
		err_clr = 8'h00;
		st_ev = 7'h00;
		repeat (3) @(negedge i_clk);
		chk8(st_flags, 8'h40);
		chk8(pir, 8'h04);
		$display("interrupt test done");
	endtask
	initial
	begin
		{module_en, ptr_rst, cpu_sel, cpu_we, tok_valid, out_tgl, out_err} = '0;
		{cpu_addr, wdata, tok_pid, tok_ep, out_len} = '0;
		{st_ev, st_clr, st_en, err_ev, err_clr, err_en} = '0;
		mode = MODE_NONE;
		i_reset = 1'b1;
		repeat (5) @(negedge i_clk);
		i_reset = 1'b0;
		module_en = 1'b1;
		t_out();
		t_in();
		t_tog();
		t_pp();
		t_map();
		t_irq();
		final_report();
	end
	initial
	begin
		repeat (6000) @(posedge i_clk);
		n_errors++;
		final_report();
	end
endmodule
`default_nettype wire
